/* verilog/llr_pkg.sv */
package llr_pkg;
    localparam int LVL_W = 16;
    localparam int ADDR_W = 8;
    localparam int NUM_IRQ = 4;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PAIR1_CFG = 8'h04;
    localparam logic [7:0] ADDR_PAIR2_CFG = 8'h08;
    localparam logic [7:0] ADDR_PAIR1_LIM = 8'h0C;
    localparam logic [7:0] ADDR_PAIR2_LIM = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

    // Alarm output selection
    localparam logic [1:0] ALM_LOW = 2'h0;
    localparam logic [1:0] ALM_HIGH = 2'h1;
    localparam logic [1:0] ALM_HOLD = 2'h2;
    // Channel, routing, mode, failsafe and fault response codes
    localparam logic [1:0] CHAN_1 = 2'h1;
    localparam logic [1:0] CHAN_2 = 2'h2;
    localparam logic [2:0] MODE_PRESS = 3'h3;
    localparam logic FS_MIN = 1'b0;
    localparam logic FS_MAX = 1'b1;
    localparam logic RESP_DEENERGISE = 1'b0;
    localparam logic RESP_FOLLOW = 1'b1;

    // Analogue output in 0.1 percent of range
    localparam logic [15:0] AO_ALARM_LOW = 16'hFF9C;
    localparam logic [15:0] AO_ALARM_HIGH = 16'h044C;
    localparam logic [15:0] AO_RST = 16'h0000;

    // Interrupt and status bit positions
    localparam int IRQ_FAULT_SET = 0;
    localparam int IRQ_FAULT_CLR = 1;
    localparam int IRQ_PAIR1 = 2;
    localparam int IRQ_PAIR2 = 3;
    localparam int ST_FAULT = 0;
    localparam int ST_ALARM_RELAY = 1;
    localparam int ST_PAIR1 = 2;
    localparam int ST_PAIR2 = 3;

    typedef struct packed {
        logic ch2_signal_range_sel;
        logic ch1_signal_range_sel;
        logic [1:0] ch2_alarm_output_sel;
        logic [1:0] ch1_alarm_output_sel;
        logic [1:0] output2_route_sel;
        logic [2:0] op_mode;
    } llr_ctrl_t;

    typedef struct packed {
        logic [1:0] channel_sel;
        logic fault_response;
        logic failsafe_sel;
    } llr_pair_cfg_t;

    typedef struct packed {
        logic [15:0] hysteresis;
        logic [15:0] switch_point;
    } llr_pair_lim_t;

    localparam llr_ctrl_t CTRL_RST = '{1'b0, 1'b0, ALM_HIGH, ALM_HIGH, CHAN_2, 3'h0};
    localparam llr_pair_cfg_t PAIR1_CFG_RST = '{CHAN_1, RESP_DEENERGISE, FS_MIN};
    localparam llr_pair_cfg_t PAIR2_CFG_RST = '{CHAN_2, RESP_DEENERGISE, FS_MIN};
    localparam llr_pair_lim_t LIM_RST = '{16'h0000, 16'h0000};
endpackage : llr_pkg

/* verilog/llr_alarm_relay.sv */
// Notes on behaviour
// - On fault each output goes to -10%, +110% or holds, per its alarm setting
// - Hold setting still drops alarm relay and lights its LED on fault
// - In mode 3 output 2 follows channel 1 or 2 per routing setting
// - Alarm relay always de-energises while a fault is present
// - Four limit relays form two pairs; both relays of a pair switch together
// - Each pair compares its channel level with its own switch point
// - Minimum mode: pair de-energises when level falls below switch point
// - Maximum mode: pair de-energises when level rises above switch point
// - Outside a fault, pair re-energises only after level moves back past the hysteresis
// - On fault a pair de-energises, or follows the output alarm, per setting
// - Following: -10% drops min, energises max; +110% the reverse
// - Each pair takes channel 1 or 2; both may share one channel
// - Limit LED lit when energised; alarm LED lit when alarm relay de-energised
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/10ps
module llr_alarm_relay (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [llr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fault_in,
    input wire logic [llr_pkg::LVL_W-1:0] ch1_level,
    input wire logic [llr_pkg::LVL_W-1:0] ch2_level,
    input wire logic [llr_pkg::LVL_W-1:0] ch1_span,
    input wire logic [llr_pkg::LVL_W-1:0] ch2_span,
    output logic [llr_pkg::LVL_W-1:0] ao1_value,
    output logic [llr_pkg::LVL_W-1:0] ao2_value,
    output logic [1:0] relay_a,
    output logic [1:0] relay_b,
    output logic [1:0] relay_led,
    output logic alarm_relay,
    output logic alarm_led,
    output logic irq
);
    import llr_pkg::*;

    llr_ctrl_t ctrl_reg;
    llr_pair_cfg_t cfg_reg [2];
    llr_pair_lim_t lim_reg [2];
    logic [NUM_IRQ-1:0] irq_stat_reg;
    logic [NUM_IRQ-1:0] irq_mask_reg;
    logic [NUM_IRQ-1:0] events;
    logic [NUM_IRQ-1:0] w1c;
    logic fault_q_reg;
    logic [1:0] relay_reg;
    logic [1:0] relay_next;
    logic [LVL_W-1:0] ao1_reg;
    logic [LVL_W-1:0] ao2_reg;
    logic [LVL_W-1:0] ao1_next;
    logic [LVL_W-1:0] ao2_next;
    logic alarm_relay_reg;
    logic alarm_led_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic setup;
    logic wr_en;

    function automatic logic signed [17:0] sx(input logic [15:0] v);
        sx = {v[15], v[15], v};
    endfunction : sx

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_CTRL, ADDR_PAIR1_CFG, ADDR_PAIR2_CFG, ADDR_PAIR1_LIM,
            ADDR_PAIR2_LIM, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction : addr_hit

    // APB slave, one-cycle access phase
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_reg & pwrite;
    assign w1c = (wr_en && paddr == ADDR_IRQ_STAT) ? pwdata[NUM_IRQ-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~addr_hit(paddr);
            prdata_reg <= 32'h00000000;
            if (setup && !pwrite) begin
                case (paddr)
                    ADDR_CTRL: prdata_reg <= {21'h000000, ctrl_reg};
                    ADDR_PAIR1_CFG: prdata_reg <= {28'h0000000, cfg_reg[0]};
                    ADDR_PAIR2_CFG: prdata_reg <= {28'h0000000, cfg_reg[1]};
                    ADDR_PAIR1_LIM: prdata_reg <= lim_reg[0];
                    ADDR_PAIR2_LIM: prdata_reg <= lim_reg[1];
                    ADDR_STATUS: prdata_reg <= {28'h0000000, relay_reg, alarm_relay_reg,
                                                fault_q_reg};
                    ADDR_IRQ_STAT: prdata_reg <= {28'h0000000, irq_stat_reg};
                    ADDR_IRQ_MASK: prdata_reg <= {28'h0000000, irq_mask_reg};
                    default: prdata_reg <= 32'h00000000;
                endcase
            end
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            cfg_reg[0] <= PAIR1_CFG_RST;
            cfg_reg[1] <= PAIR2_CFG_RST;
            lim_reg[0] <= LIM_RST;
            lim_reg[1] <= LIM_RST;
            irq_mask_reg <= '0;
        end else if (wr_en) begin
            case (paddr)
                ADDR_CTRL: ctrl_reg <= pwdata[$bits(llr_ctrl_t)-1:0];
                ADDR_PAIR1_CFG: cfg_reg[0] <= pwdata[$bits(llr_pair_cfg_t)-1:0];
                ADDR_PAIR2_CFG: cfg_reg[1] <= pwdata[$bits(llr_pair_cfg_t)-1:0];
                ADDR_PAIR1_LIM: lim_reg[0] <= pwdata;
                ADDR_PAIR2_LIM: lim_reg[1] <= pwdata;
                ADDR_IRQ_MASK: irq_mask_reg <= pwdata[NUM_IRQ-1:0];
                default: ;
            endcase
        end
    end

    // Analogue outputs
    always_comb begin
        ao1_next = ch1_span;
        ao2_next = ch2_span;
        if (ctrl_reg.op_mode == MODE_PRESS && ctrl_reg.output2_route_sel == CHAN_1) begin
            ao2_next = ch1_span;
        end
        if (fault_in) begin
            case (ctrl_reg.ch1_alarm_output_sel)
                ALM_LOW: ao1_next = AO_ALARM_LOW;
                ALM_HIGH: ao1_next = AO_ALARM_HIGH;
                default: ao1_next = ao1_reg;
            endcase
            case (ctrl_reg.ch2_alarm_output_sel)
                ALM_LOW: ao2_next = AO_ALARM_LOW;
                ALM_HIGH: ao2_next = AO_ALARM_HIGH;
                default: ao2_next = ao2_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ao1_reg <= AO_RST;
            ao2_reg <= AO_RST;
        end else begin
            ao1_reg <= ao1_next;
            ao2_reg <= ao2_next;
        end
    end

    // Limit relay pairs
    for (genvar p = 0; p < 2; p++) begin : g_pair
        logic signed [17:0] lvl;
        logic signed [17:0] sp;
        logic signed [17:0] up;
        logic signed [17:0] dn;
        logic [1:0] asel;
        assign lvl = (cfg_reg[p].channel_sel == CHAN_2) ? sx(ch2_level) : sx(ch1_level);
        assign asel = (cfg_reg[p].channel_sel == CHAN_2) ? ctrl_reg.ch2_alarm_output_sel
                                                         : ctrl_reg.ch1_alarm_output_sel;
        assign sp = sx(lim_reg[p].switch_point);
        assign up = sp + $signed({2'b00, lim_reg[p].hysteresis});
        assign dn = sp - $signed({2'b00, lim_reg[p].hysteresis});

        always_comb begin
            relay_next[p] = relay_reg[p];
            if (fault_in) begin
                if (cfg_reg[p].fault_response == RESP_DEENERGISE) begin
                    relay_next[p] = 1'b0;
                end else begin
                    case (asel)
                        ALM_LOW: relay_next[p] = (cfg_reg[p].failsafe_sel == FS_MAX);
                        ALM_HIGH: relay_next[p] = (cfg_reg[p].failsafe_sel == FS_MIN);
                        default: relay_next[p] = relay_reg[p];
                    endcase
                end
            end else if (cfg_reg[p].failsafe_sel == FS_MIN) begin
                if (relay_reg[p] && lvl < sp) begin
                    relay_next[p] = 1'b0;
                end else if (!relay_reg[p] && lvl > up) begin
                    relay_next[p] = 1'b1;
                end
            end else begin
                if (relay_reg[p] && lvl > sp) begin
                    relay_next[p] = 1'b0;
                end else if (!relay_reg[p] && lvl < dn) begin
                    relay_next[p] = 1'b1;
                end
            end
        end

        AST_MIN_DROP: assert property (@(posedge pclk) disable iff (!presetn)
            !fault_in && cfg_reg[p].failsafe_sel == FS_MIN && lvl < sp |=> !relay_a[p])
            else $error("minimum mode pair did not drop");
        AST_MAX_DROP: assert property (@(posedge pclk) disable iff (!presetn)
            !fault_in && cfg_reg[p].failsafe_sel == FS_MAX && lvl > sp |=> !relay_a[p])
            else $error("maximum mode pair did not drop");
        AST_HYST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
            !fault_in && !relay_a[p] && cfg_reg[p].failsafe_sel == FS_MIN && lvl <= up
            |=> !relay_a[p])
            else $error("pair energised inside hysteresis band");
        AST_HYST_HOLD_MAX: assert property (@(posedge pclk) disable iff (!presetn)
            !fault_in && !relay_a[p] && cfg_reg[p].failsafe_sel == FS_MAX && lvl >= dn
            |=> !relay_a[p])
            else $error("maximum mode pair energised inside hysteresis band");
        AST_FAULT_DROP: assert property (@(posedge pclk) disable iff (!presetn)
            fault_in && cfg_reg[p].fault_response == RESP_DEENERGISE |=> !relay_a[p])
            else $error("pair energised during fault");
        AST_FOLLOW_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
            fault_in && cfg_reg[p].fault_response == RESP_FOLLOW && asel == ALM_HIGH
            |=> relay_a[p] == (($past(cfg_reg[p].failsafe_sel)) == FS_MIN))
            else $error("pair did not follow +110 alarm");
        AST_FOLLOW_LOW: assert property (@(posedge pclk) disable iff (!presetn)
            fault_in && cfg_reg[p].fault_response == RESP_FOLLOW && asel == ALM_LOW
            |=> relay_a[p] == (($past(cfg_reg[p].failsafe_sel)) == FS_MAX))
            else $error("pair did not follow -10 alarm");
        // Drop and re-energise cycle
        COV_PAIR_CYCLE: cover property (@(posedge pclk) disable iff (!presetn)
            $fell(relay_a[p]) ##[1:40] $rose(relay_a[p]));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_reg <= 2'h0;
        end else begin
            relay_reg <= relay_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_relay_reg <= 1'b0;
            alarm_led_reg <= 1'b1;
            fault_q_reg <= 1'b0;
        end else begin
            alarm_relay_reg <= ~fault_in;
            alarm_led_reg <= fault_in;
            fault_q_reg <= fault_in;
        end
    end

    // Sticky interrupt status, set beats clear
    assign events[IRQ_FAULT_SET] = fault_in & ~fault_q_reg;
    assign events[IRQ_FAULT_CLR] = ~fault_in & fault_q_reg;
    assign events[IRQ_PAIR1] = relay_next[0] ^ relay_reg[0];
    assign events[IRQ_PAIR2] = relay_next[1] ^ relay_reg[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ao1_value = ao1_reg;
    assign ao2_value = ao2_reg;
    assign relay_a = relay_reg;
    assign relay_b = relay_reg;
    assign relay_led = relay_reg;
    assign alarm_relay = alarm_relay_reg;
    assign alarm_led = alarm_led_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_AO_LOW: assert property (
        fault_in && ctrl_reg.ch1_alarm_output_sel == ALM_LOW |=> ao1_value == AO_ALARM_LOW)
        else $error("output 1 not at low alarm value");
    AST_AO_HIGH: assert property (
        fault_in && ctrl_reg.ch1_alarm_output_sel == ALM_HIGH |=> ao1_value == AO_ALARM_HIGH)
        else $error("output 1 not at high alarm value");
    AST_AO_HOLD: assert property (
        fault_in && ctrl_reg.ch2_alarm_output_sel == ALM_HOLD |=> $stable(ao2_value))
        else $error("output 2 not held on fault");
    AST_HOLD_ALARM: assert property (
        fault_in && ctrl_reg.ch2_alarm_output_sel == ALM_HOLD
        |=> !alarm_relay && alarm_led && $stable(ao2_value))
        else $error("hold mode did not raise alarm");
    AST_ROUTE: assert property (
        !fault_in && ctrl_reg.op_mode == MODE_PRESS && ctrl_reg.output2_route_sel == CHAN_1
        |=> ao2_value == $past(ch1_span))
        else $error("output 2 not routed to channel 1");
    AST_ROUTE_CH2: assert property (
        !fault_in && ctrl_reg.op_mode == MODE_PRESS && ctrl_reg.output2_route_sel == CHAN_2
        |=> ao2_value == $past(ch2_span))
        else $error("output 2 not routed to channel 2");
    AST_ALARM_RELAY: assert property (fault_in |=> !alarm_relay && alarm_led)
        else $error("alarm relay energised during fault");
    AST_PAIR_TOGETHER: assert property (relay_a == relay_b)
        else $error("pair relays differ");
    AST_LEDS: assert property (relay_led == relay_a && alarm_led != alarm_relay)
        else $error("indicator does not match relay");
    AST_RECOVER: assert property ($fell(fault_in) |-> ##1 alarm_relay && !alarm_led)
        else $error("alarm relay not restored");
    // Interrupt follows masked status
    AST_IRQ: assert property (
        ##1 irq == |($past(irq_stat_reg) & $past(irq_mask_reg)))
        else $error("interrupt output mismatch");

    COV_HOLD_FAULT: cover property (
        fault_in && ctrl_reg.ch2_alarm_output_sel == ALM_HOLD ##1 !fault_in);
    COV_ROUTE: cover property (ctrl_reg.op_mode == MODE_PRESS && !fault_in);
    COV_IRQ: cover property ($rose(irq));
endmodule : llr_alarm_relay

/* test/llr_field_model.sv */
`timescale 1ns/10ps
module llr_field_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] relay_a,
    input wire logic [1:0] relay_b,
    output logic contact_split
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contact_split <= 1'b0;
        end else if (relay_a !== relay_b) begin
            contact_split <= 1'b1;
        end
    end
endmodule : llr_field_model

/* test/level_limit_relay_alarm_logic_tb.sv */
`timescale 1ns/10ps
module level_limit_relay_alarm_logic_tb;
    import llr_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic fault_in = 1'b0;
    logic [LVL_W-1:0] ch1_level = '0;
    logic [LVL_W-1:0] ch2_level = '0;
    logic [LVL_W-1:0] ch1_span = '0;
    logic [LVL_W-1:0] ch2_span = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [LVL_W-1:0] ao1_value;
    logic [LVL_W-1:0] ao2_value;
    logic [1:0] relay_a;
    logic [1:0] relay_b;
    logic [1:0] relay_led;
    logic alarm_relay;
    logic alarm_led;
    logic irq;
    logic contact_split;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int total_checks = 0;

    always #2.5 pclk = ~pclk;

    llr_alarm_relay dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_in(fault_in), .ch1_level(ch1_level), .ch2_level(ch2_level),
        .ch1_span(ch1_span), .ch2_span(ch2_span), .ao1_value(ao1_value),
        .ao2_value(ao2_value), .relay_a(relay_a), .relay_b(relay_b), .relay_led(relay_led),
        .alarm_relay(alarm_relay), .alarm_led(alarm_led), .irq(irq)
    );

    llr_field_model field (
        .pclk(pclk), .presetn(presetn), .relay_a(relay_a), .relay_b(relay_b),
        .contact_split(contact_split)
    );

    task end_of_test;
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : step

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_total++;
            end_of_test();
        end
    endtask : apb

    task lv(input logic c2, input logic [15:0] l);
        @(posedge pclk);
        ch1_level <= c2 ? 16'h0000 : l;
        ch2_level <= c2 ? l : 16'h0000;
        step(3);
    endtask : lv

    task t_reset;
        step(1);
        chk(alarm_relay, 1'b1);
        chk(alarm_led, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_00B0);
        apb(1'b0, ADDR_PAIR1_CFG, 32'h0);
        chk(rd, 32'h0000_0004);
        apb(1'b0, ADDR_PAIR2_CFG, 32'h0);
        chk(rd, 32'h0000_0008);
        apb(1'b0, ADDR_IRQ_MASK, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        chk(er, 1'b1);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0000_0000);
    endtask : t_reset

    task t_pair(input logic [7:0] ca, input logic [31:0] cv, input logic [7:0] la,
            input int p, input logic c2, input logic [15:0] l [5]);
        logic [4:0] e;
        e = 5'b10011;
        apb(1'b1, ca, cv);
        apb(1'b1, la, p ? 32'h0028_005A : 32'h0028_000A);
        apb(1'b0, la, 32'h0);
        chk(rd, p ? 32'h0028_005A : 32'h0028_000A);
        for (int i = 0; i < 5; i++) begin
            lv(c2, l[i]);
            chk(relay_a[p], e[i]);
            chk(relay_b[p], e[i]);
            chk(relay_led[p], e[i]);
        end
    endtask : t_pair

    task t_fault;
        apb(1'b1, ADDR_PAIR2_CFG, 32'h0000_0008);
        apb(1'b1, ADDR_PAIR2_LIM, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CTRL, {23'h0, 3'b100, i[1], 5'h10});
            apb(1'b1, ADDR_PAIR1_CFG, {28'h0, 3'b011, i[0]});
            @(posedge pclk);
            ch1_span <= 16'h01F4;
            ch2_span <= 16'h012C;
            ch2_level <= 16'h0064;
            step(3);
            @(posedge pclk);
            fault_in <= 1'b1;
            ch2_span <= 16'h02BC;
            step(3);
            chk(ao1_value, i[1] ? AO_ALARM_HIGH : AO_ALARM_LOW);
            chk(ao2_value, 16'h012C);
            chk(alarm_relay, 1'b0);
            chk(alarm_led, 1'b1);
            chk(relay_a[0], i[0] ^ i[1]);
            chk(relay_a[1], 1'b0);
            apb(1'b0, ADDR_STATUS, 32'h0);
            chk(rd, {28'h0, 1'b0, i[0] ^ i[1], 2'b01});
            if (i == 0) begin
                chk(irq, 1'b0);
            end
            @(posedge pclk);
            fault_in <= 1'b0;
            step(3);
            chk(alarm_relay, 1'b1);
            chk(ao2_value, 16'h02BC);
        end
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
        step(2);
        chk(irq, 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h0000_000F);
        step(2);
        chk(irq, 1'b0);
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk(rd, 32'h0000_0000);
    endtask : t_fault

    task t_route;
        apb(1'b1, ADDR_CTRL, 32'h0000_00AB);
        @(posedge pclk);
        ch1_span <= 16'h00FA;
        ch2_span <= 16'h028A;
        step(3);
        chk(ao2_value, 16'h00FA);
        apb(1'b1, ADDR_CTRL, 32'h0000_00B3);
        step(3);
        chk(ao2_value, 16'h028A);
    endtask : t_route

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_pair(ADDR_PAIR1_CFG, 32'h4, ADDR_PAIR1_LIM, 0, 1'b0,
            '{16'h003C, 16'h001E, 16'h0009, 16'h0032, 16'h0033});
        t_pair(ADDR_PAIR2_CFG, 32'h9, ADDR_PAIR2_LIM, 1, 1'b1,
            '{16'h0031, 16'h005A, 16'h005B, 16'h0032, 16'h0031});
        t_pair(ADDR_PAIR2_CFG, 32'h5, ADDR_PAIR2_LIM, 1, 1'b0,
            '{16'h0031, 16'h005A, 16'h005B, 16'h0032, 16'h0031});
        t_fault();
        t_route();
        chk(contact_split, 1'b0);
        end_of_test();
    end
endmodule : level_limit_relay_alarm_logic_tb
